// file: src/fcs_flash_ctrl.sv
// Purpose: Flash clock ratio, working options, key routing and access blocking.
// Assumes: Source and target class of each memory access come from the bus decoder.
// Notes: Memory outputs are registered, one cycle behind the access.
`default_nettype none
module fcs_flash_ctrl import fcs_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [7:0]  reg_rdata,
  input  wire logic [7:0]  nonvolatile_options_byte,
  input  wire logic [63:0] backdoor_key_bytes,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_we,
  input  wire logic        mem_re,
  input  wire logic        mem_to_secure,
  input  wire logic        mem_to_flash,
  input  wire logic        mem_from_secure,
  input  wire logic        background_debug_mode,
  input  wire logic [7:0]  array_rdata,
  input  wire logic        blank_check_ok,
  output logic      [7:0]  mem_rdata,
  output logic             ram_we,
  output logic             flash_cmd_start,
  output logic             flash_cmd_refused,
  output logic      [15:0] wr_addr,
  output logic      [7:0]  wr_data,
  output logic             fclk_tick,
  output logic             pe_allowed,
  output logic             secure,
  output logic             redirect_enable
);
  fcs_link_if lnk ();

  logic       ratio_written_flag;
  logic       prescale_by_eight;
  logic [5:0] ratio_field;
  logic [7:0] options_working_reg;
  logic       opt_loaded;
  logic       unlock_compare_mode;
  logic       blocked;
  logic       key_window;
  logic       cmd_try;
  logic       cfg_wr;
  logic       key_unlock;
  logic [9:0] period_cyc;
  logic       period_ok;
  logic [7:0] next_rdata;

  fcs_clk_div u_div (
    .clk   (clk),
    .rst_n (rst_n),
    .lnk   (lnk.div)
  );

  fcs_key_cmp u_key (
    .clk                (clk),
    .rst_n              (rst_n),
    .backdoor_key_bytes (backdoor_key_bytes),
    .lnk                (lnk.key)
  );

  // Clock ratio register: one write per reset, later ones dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ratio_written_flag <= 1'b0;
      prescale_by_eight  <= 1'b0;
      ratio_field        <= 6'h00;
    end else if (reg_we && reg_addr == REG_RATIO && !ratio_written_flag) begin
      ratio_written_flag <= 1'b1;
      prescale_by_eight  <= reg_wdata[PRESCALE_BIT];
      ratio_field        <= reg_wdata[5:0];
    end
  end

  // Divider only runs once a ratio is in place
  assign lnk.prescale = prescale_by_eight;
  assign lnk.ratio    = ratio_field;
  assign lnk.run      = ratio_written_flag;
  assign fclk_tick    = lnk.tick;
  assign pe_allowed   = ratio_written_flag;

  // Length of one flash clock in bus cycles, for the range status bit
  assign period_cyc = prescale_by_eight ? {1'b0, ratio_field + 6'h00, 3'h0} + 10'h008
                                        : {4'h0, ratio_field} + 10'h001;
  assign period_ok  = ratio_written_flag
                   && period_cyc >= 10'(PULSE_MIN_CYC)
                   && period_cyc <= 10'(PULSE_MAX_CYC);

  // Working options: caught from the nonvolatile byte on the first edge after reset.
  // Strap is not sampled under reset itself, so the erased (secure) value stands there.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_loaded <= 1'b0;
    end else begin
      opt_loaded <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      options_working_reg <= OPT_RESET;
    end else if (!opt_loaded) begin
      options_working_reg <= nonvolatile_options_byte;
    end else if (key_unlock || blank_check_ok) begin
      options_working_reg[1:0] <= LOCK_OPEN;
    end
  end
  // Software writes to REG_OPT fall through on purpose

  assign key_unlock      = lnk.key_match && options_working_reg[OPT_BACKDOOR_UNLOCK_ENABLE_BIT];
  assign secure          = options_working_reg[1:0] != LOCK_OPEN;
  assign redirect_enable = !options_working_reg[OPT_NORED_BIT];

  // Configuration register: compare mode, with start and check on its edges
  assign cfg_wr = reg_we && reg_addr == REG_CFG;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_compare_mode <= 1'b0;
    end else if (cfg_wr) begin
      unlock_compare_mode <= reg_wdata[CFG_UNLOCK_COMPARE_MODE_BIT];
    end
  end

  assign lnk.key_start = cfg_wr && reg_wdata[CFG_UNLOCK_COMPARE_MODE_BIT] && !unlock_compare_mode;
  assign lnk.key_check = cfg_wr && !reg_wdata[CFG_UNLOCK_COMPARE_MODE_BIT] && unlock_compare_mode;

  // Access control toward RAM and flash
  assign blocked    = secure && mem_to_secure
                   && (!mem_from_secure || background_debug_mode);
  assign key_window = mem_addr >= KEY_BASE && mem_addr <= KEY_LAST;

  // Key values only from secure firmware, never from the debug port
  assign lnk.key_wr   = mem_we && key_window && unlock_compare_mode
                     && mem_from_secure && !background_debug_mode;
  assign lnk.key_idx  = mem_addr[2:0];
  assign lnk.key_data = mem_wdata;

  // A debug write to the window in compare mode goes nowhere
  assign cmd_try = mem_we && mem_to_flash && !blocked
                && !(key_window && unlock_compare_mode);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_cmd_start   <= 1'b0;
      flash_cmd_refused <= 1'b0;
      ram_we            <= 1'b0;
    end else begin
      flash_cmd_start   <= cmd_try && ratio_written_flag;
      flash_cmd_refused <= cmd_try && !ratio_written_flag;
      ram_we            <= mem_we && !mem_to_flash && !blocked;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_addr <= 16'h0000;
      wr_data <= 8'h00;
    end else if (mem_we) begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rdata <= 8'h00;
    end else if (mem_re && !blocked) begin
      mem_rdata <= array_rdata;
    end else begin
      mem_rdata <= 8'h00;
    end
  end

  // Register read port: data valid only in the cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (reg_re) begin
      case (reg_addr)
        REG_RATIO: next_rdata = {ratio_written_flag, prescale_by_eight, ratio_field};
        REG_OPT:   next_rdata = options_working_reg & OPT_RD_MASK;
        REG_CFG:   next_rdata = {2'h0, unlock_compare_mode, 5'h00} & CFG_RD_MASK;
        REG_STAT:  next_rdata = {5'h00, pe_allowed, secure, period_ok};
        default:   next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  chk_ratio_first_write: assert property (@(posedge clk) disable iff (!rst_n)
    reg_we && reg_addr == REG_RATIO && !ratio_written_flag
    |=> ratio_written_flag && ratio_field == $past(reg_wdata[5:0])
        && prescale_by_eight == $past(reg_wdata[PRESCALE_BIT]))
    else $error("first ratio write not taken");

  chk_ratio_locked: assert property (@(posedge clk) disable iff (!rst_n)
    ratio_written_flag |=> ratio_written_flag && $stable(ratio_field)
                           && $stable(prescale_by_eight))
    else $error("ratio changed after first write");

  chk_ratio_readback: assert property (@(posedge clk) disable iff (!rst_n)
    reg_re && reg_addr == REG_RATIO
    |=> reg_rdata == {$past(ratio_written_flag), $past(prescale_by_eight),
                      $past(ratio_field)})
    else $error("ratio readback wrong");

  chk_cmd_gated: assert property (@(posedge clk) disable iff (!rst_n)
    mem_we && mem_to_flash && !blocked && !key_window && !ratio_written_flag
    |=> !flash_cmd_start && flash_cmd_refused)
    else $error("command started before ratio written");

  chk_key_route: assert property (@(posedge clk) disable iff (!rst_n)
    mem_we && key_window && unlock_compare_mode |=> !flash_cmd_start)
    else $error("key window write started a command");

  chk_debug_no_key: assert property (@(posedge clk) disable iff (!rst_n)
    background_debug_mode |-> !lnk.key_wr)
    else $error("debug access reached the key compare");

  chk_blocked_read: assert property (@(posedge clk) disable iff (!rst_n)
    mem_re && blocked |=> mem_rdata == 8'h00)
    else $error("blocked read returned data");

  chk_blocked_write: assert property (@(posedge clk) disable iff (!rst_n)
    mem_we && blocked |=> !ram_we && !flash_cmd_start)
    else $error("blocked write passed");

  chk_key_unlock: assert property (@(posedge clk) disable iff (!rst_n)
    opt_loaded && lnk.key_match && options_working_reg[OPT_BACKDOOR_UNLOCK_ENABLE_BIT]
    |=> !secure [*2])
    else $error("key match did not unlock");

  chk_backdoor_unlock_enable_off: assert property (@(posedge clk) disable iff (!rst_n)
    opt_loaded && secure && !options_working_reg[OPT_BACKDOOR_UNLOCK_ENABLE_BIT] && !blank_check_ok
    |=> secure)
    else $error("unlocked with key mechanism off");

  chk_opt_no_sw: assert property (@(posedge clk) disable iff (!rst_n)
    opt_loaded && !key_unlock && !blank_check_ok |=> $stable(options_working_reg))
    else $error("options register changed");

  chk_opt_load: assert property (@(posedge clk) disable iff (!rst_n)
    !opt_loaded |=> options_working_reg == $past(nonvolatile_options_byte))
    else $error("options not loaded after reset");

  chk_lock_decode: assert property (@(posedge clk) disable iff (!rst_n)
    secure == (options_working_reg[1:0] != 2'h2)
    && redirect_enable == !options_working_reg[6])
    else $error("lock or redirect decode wrong");

  chk_blank_unlock: assert property (@(posedge clk) disable iff (!rst_n)
    opt_loaded && blank_check_ok |=> !secure)
    else $error("blank check did not unlock");

  cov_cmd_start: cover property (@(posedge clk) disable iff (!rst_n) flash_cmd_start);
  cov_blocked_rd: cover property (@(posedge clk) disable iff (!rst_n) mem_re && blocked);
  cov_unlock: cover property (@(posedge clk) disable iff (!rst_n) secure ##1 !secure);
endmodule : fcs_flash_ctrl
`default_nettype wire

// file: include/fcs_pkg.sv
// Purpose: Constants and types of the flash clock, options and key block.
// Assumes: 8-bit registers on a plain strobe port, one 10 MHz clock.
// Notes on behaviour
// - Ratio register reads bits 6:0 always; they take one write per reset; bit 7 read-only.
// - Reset clears the written flag; the first ratio write sets it, any value.
// - Program and erase are refused until the written flag is set.
// - Prescale bit 6 picks bus clock, or bus clock divided by eight.
// - Flash clock is the divider input divided by ratio field plus one.
// - Each timing pulse is one flash clock period, 5 us to 6.7 us; any ratio is accepted, and status bit 0 only flags whether it is in range.
// - Working options load from the nonvolatile byte on the first edge after reset only.
// - With key enable bit 7 clear, no key match unlocks the device.
// - Only secure firmware may write key values; debug writes cannot.
// - Eight matching key bytes written in order unlock until next reset.
// - Options bit 6 set disables vector redirection; clear enables it.
// - Lock code 1:0 alone means unsecured; the other three mean secure.
// - While secure, secure memory is closed to unsecured sources and debug.
// - Lock code becomes 1:0 after key match or a good blank check.
// - Config bit 5 routes key-window writes to compare, else to commands.
// - Blocked accesses: writes ignored, reads give all zeros.
// - Key bytes go in ascending order, never adjacent; clearing bit 5 compares.
`default_nettype none
package fcs_pkg;
  localparam logic [3:0]  REG_RATIO      = 4'h0;
  localparam logic [3:0]  REG_OPT        = 4'h1;
  localparam logic [3:0]  REG_CFG        = 4'h2;
  localparam logic [3:0]  REG_STAT       = 4'h3;
  localparam int          RATIO_FLAG_BIT = 7;
  localparam int          PRESCALE_BIT   = 6;
  localparam int          OPT_BACKDOOR_UNLOCK_ENABLE_BIT  = 7;
  localparam int          OPT_NORED_BIT  = 6;
  localparam int          CFG_UNLOCK_COMPARE_MODE_BIT = 5;
  localparam int          STAT_PERIOD_OK = 0;
  localparam int          STAT_SECURE    = 1;
  localparam int          STAT_PE_OK     = 2;
  localparam logic [1:0]  LOCK_OPEN      = 2'h2;
  localparam logic [7:0]  OPT_RESET      = 8'hff;
  localparam logic [7:0]  OPT_RD_MASK    = 8'hc3;
  localparam logic [7:0]  CFG_RD_MASK    = 8'h20;
  localparam logic [15:0] KEY_BASE       = 16'hffb0;
  localparam logic [15:0] KEY_LAST       = 16'hffb7;
  localparam logic [3:0]  KEY_BYTES      = 4'h8;
  localparam logic [2:0]  PRE_LAST       = 3'h7;
  localparam int          BUS_PERIOD_NS  = 100;
  localparam int          PULSE_MIN_NS   = 5000;
  localparam int          PULSE_MAX_NS   = 6700;
  localparam int          PULSE_MIN_CYC  = (PULSE_MIN_NS + BUS_PERIOD_NS - 1) / BUS_PERIOD_NS;
  localparam int          PULSE_MAX_CYC  = PULSE_MAX_NS / BUS_PERIOD_NS;
  typedef enum logic {KEY_IDLE, KEY_COLLECT} fcs_key_state_t;
endpackage : fcs_pkg
`default_nettype wire

// file: include/fcs_link_if.sv
// Purpose: Carries divider settings and key traffic between the core and its helpers.
// Assumes: One clock domain; all signals are levels or one-cycle pulses.
// Notes: The core drives settings and strobes; helpers answer with tick and match.
`default_nettype none
interface fcs_link_if;
  logic       prescale;
  logic [5:0] ratio;
  logic       run;
  logic       tick;
  logic       key_start;
  logic       key_check;
  logic       key_wr;
  logic [2:0] key_idx;
  logic [7:0] key_data;
  logic       key_match;
  modport core (output prescale, ratio, run, key_start, key_check, key_wr, key_idx,
                key_data, input tick, key_match);
  modport div  (input prescale, ratio, run, output tick);
  modport key  (input key_start, key_check, key_wr, key_idx, key_data, output key_match);
endinterface : fcs_link_if
`default_nettype wire

// file: src/fcs_clk_div.sv
// Purpose: Derives the flash timing tick from the bus clock.
// Assumes: Settings stay still while run is high.
// Notes: tick is one bus cycle wide, once per flash clock period.
`default_nettype none
module fcs_clk_div import fcs_pkg::*; (
  input  wire logic clk,
  input  wire logic rst_n,
  fcs_link_if.div   lnk
);
  logic [2:0] pre_cnt;
  logic [5:0] div_cnt;
  logic       pre_tick;

  assign pre_tick = !lnk.prescale || (pre_cnt == PRE_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 3'h0;
    end else if (!lnk.run || pre_tick) begin
      pre_cnt <= 3'h0;
    end else begin
      pre_cnt <= pre_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt  <= 6'h00;
      lnk.tick <= 1'b0;
    end else if (!lnk.run) begin
      div_cnt  <= 6'h00;
      lnk.tick <= 1'b0;
    end else if (pre_tick && div_cnt == lnk.ratio) begin
      div_cnt  <= 6'h00;
      lnk.tick <= 1'b1;
    end else begin
      div_cnt  <= pre_tick ? div_cnt + 6'h01 : div_cnt;
      lnk.tick <= 1'b0;
    end
  end

  chk_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    lnk.tick && lnk.run && (lnk.ratio != 6'h00 || lnk.prescale) |=> !lnk.tick)
    else $error("flash tick repeated too soon");
  cov_tick: cover property (@(posedge clk) disable iff (!rst_n) lnk.tick);
endmodule : fcs_clk_div
`default_nettype wire

// file: src/fcs_key_cmp.sv
// Purpose: Collects the eight comparison bytes and checks them against the stored key.
// Assumes: Writes arrive only while compare mode is on and from secure code.
// Notes: Any slip (wrong order, adjacent cycles, wrong byte) spoils the whole attempt.
`default_nettype none
module fcs_key_cmp import fcs_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [63:0] backdoor_key_bytes,
  fcs_link_if.key          lnk
);
  fcs_key_state_t state;
  logic [3:0]     got;
  logic           bad;
  logic           last_wr;
  logic           slip;

  assign slip = last_wr || got == KEY_BYTES || {1'b0, lnk.key_idx} != got
             || lnk.key_data != backdoor_key_bytes[8*lnk.key_idx +: 8];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= KEY_IDLE;
      got   <= 4'h0;
      bad   <= 1'b0;
    end else begin
      case (state)
        KEY_IDLE: begin
          if (lnk.key_start) begin
            state <= KEY_COLLECT;
            got   <= 4'h0;
            bad   <= 1'b0;
          end
        end
        KEY_COLLECT: begin
          if (lnk.key_check) begin
            state <= KEY_IDLE;
          end else if (lnk.key_wr && slip) begin
            bad <= 1'b1;
          end else if (lnk.key_wr) begin
            got <= got + 4'h1;
          end
        end
        default: state <= KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_wr       <= 1'b0;
      lnk.key_match <= 1'b0;
    end else begin
      last_wr       <= lnk.key_wr;
      lnk.key_match <= state == KEY_COLLECT && lnk.key_check && !bad
                       && got == KEY_BYTES;
    end
  end

  chk_key_adjacent: assert property (@(posedge clk) disable iff (!rst_n)
    state == KEY_COLLECT && lnk.key_wr && last_wr && !lnk.key_check |=> bad)
    else $error("adjacent key writes not spoiled");
  cov_key_match: cover property (@(posedge clk) disable iff (!rst_n) lnk.key_match);
endmodule : fcs_key_cmp
`default_nettype wire

// file: verification/tb.sv
// Purpose: Self-checking bench for the flash clock, options and key block.
// Assumes: Register and memory ports answer on the taking edge itself, and are read just after it.
// Notes: Six resets cover lock codes, key enable and the prescaled divider.
`default_nettype none
module tb;
  import fcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic [7:0]  reg_rdata;
  logic [7:0]  nv_byte;
  logic [63:0] key;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        mem_we;
  logic        mem_re;
  logic [3:0]  mem_cls;
  logic [7:0]  array_rdata;
  logic        blank_ok;
  logic [7:0]  mem_rdata;
  logic        ram_we;
  logic        cmd_start;
  logic        cmd_refused;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic        fclk_tick;
  logic        pe_allowed;
  logic        secure;
  logic        redirect_enable;
  logic [7:0]  rv;
  int          n_mismatch;
  int          num_checks;
  int          n;

  fcs_flash_ctrl uut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .nonvolatile_options_byte(nv_byte), .backdoor_key_bytes(key),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
    .mem_to_secure(mem_cls[3]), .mem_to_flash(mem_cls[2]),
    .mem_from_secure(mem_cls[1]), .background_debug_mode(mem_cls[0]),
    .array_rdata(array_rdata), .blank_check_ok(blank_ok), .mem_rdata(mem_rdata),
    .ram_we(ram_we), .flash_cmd_start(cmd_start), .flash_cmd_refused(cmd_refused),
    .wr_addr(wr_addr), .wr_data(wr_data), .fclk_tick(fclk_tick),
    .pe_allowed(pe_allowed), .secure(secure), .redirect_enable(redirect_enable)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic results;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset(input logic [7:0] nv);
    @(posedge clk);
    rst_n   <= 1'b0;
    nv_byte <= nv;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : do_reset

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Class bits: to_secure, to_flash, from_secure, debug
  task automatic mem_op(input logic we, input logic [15:0] a, input logic [7:0] d,
                        input logic [3:0] cls);
    @(posedge clk);
    mem_we    <= we;
    mem_re    <= ~we;
    mem_addr  <= a;
    mem_wdata <= d;
    mem_cls   <= cls;
    @(posedge clk);
    mem_we <= 1'b0;
    mem_re <= 1'b0;
    #1;
  endtask : mem_op

  // One idle edge between key writes, since adjacent writes spoil the attempt
  task automatic key_entry(input logic [63:0] k, input logic dbg);
    wr(REG_CFG, 8'h20);
    for (int i = 0; i < 8; i++) begin
      mem_op(1'b1, KEY_BASE + 16'(i), k[8*i+:8], {3'b111, dbg});
      chk(16'(cmd_start), 16'h0);
    end
    wr(REG_CFG, 8'h00);
    repeat (2) @(posedge clk);
    #1;
  endtask : key_entry

  task automatic tick_gap(output int gap);
    int w;
    w   = 0;
    gap = 1;
    while (fclk_tick !== 1'b1 && w < 300) begin
      @(posedge clk);
      #1;
      w++;
    end
    @(posedge clk);
    #1;
    while (fclk_tick !== 1'b1 && gap < 300) begin
      @(posedge clk);
      #1;
      gap++;
    end
    if (w >= 300 || gap >= 300) begin
      n_mismatch++;
      results();
    end
  endtask : tick_gap

  initial begin
    rst_n = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00; reg_we = 1'b0; reg_re = 1'b0;
    nv_byte = 8'h83; key = 64'h1122334455667788; mem_addr = 16'h0000;
    mem_wdata = 8'h00; mem_we = 1'b0; mem_re = 1'b0; mem_cls = 4'h0;
    array_rdata = 8'ha5; blank_ok = 1'b0; n_mismatch = 0; num_checks = 0;
    do_reset(8'h83);
    chk(16'(secure), 16'h1);
    chk(16'(redirect_enable), 16'h1);
    rd(REG_OPT, rv); chk(16'(rv), 16'h83);
    wr(REG_OPT, 8'h00);
    rd(REG_OPT, rv); chk(16'(rv), 16'h83);
    rd(REG_RATIO, rv); chk(16'(rv), 16'h00);
    chk(16'(pe_allowed), 16'h0);
    mem_op(1'b1, 16'he000, 8'h5a, 4'b1110);
    chk(16'(cmd_refused), 16'h1);
    chk(16'(cmd_start), 16'h0);
    wr(REG_RATIO, 8'h31);
    rd(REG_RATIO, rv); chk(16'(rv), 16'hb1);
    wr(REG_RATIO, 8'h7c);
    rd(REG_RATIO, rv); chk(16'(rv), 16'hb1);
    chk(16'(pe_allowed), 16'h1);
    rd(REG_STAT, rv); chk(16'(rv), 16'h07);
    tick_gap(n); chk(16'(n), 16'd50);
    mem_op(1'b1, 16'he001, 8'h3c, 4'b1110);
    chk(16'(cmd_start), 16'h1);
    chk(wr_addr, 16'he001);
    mem_op(1'b0, 16'h0100, 8'h00, 4'b1000); chk(16'(mem_rdata), 16'h00);
    mem_op(1'b1, 16'h0100, 8'h11, 4'b1000); chk(16'(ram_we), 16'h0);
    mem_op(1'b0, 16'h0100, 8'h00, 4'b1011); chk(16'(mem_rdata), 16'h00);
    mem_op(1'b0, 16'h0100, 8'h00, 4'b1010); chk(16'(mem_rdata), 16'ha5);
    mem_op(1'b1, 16'h0100, 8'h22, 4'b1010); chk(16'(ram_we), 16'h1);
    key_entry(key ^ 64'h0100, 1'b0); chk(16'(secure), 16'h1);
    key_entry(key, 1'b1); chk(16'(secure), 16'h1);
    key_entry(key, 1'b0); chk(16'(secure), 16'h0);
    rd(REG_OPT, rv); chk(16'(rv), 16'h82);
    mem_op(1'b0, 16'h0100, 8'h00, 4'b1000); chk(16'(mem_rdata), 16'ha5);
    do_reset(8'h43);
    chk(16'(secure), 16'h1);
    chk(16'(redirect_enable), 16'h0);
    rd(REG_RATIO, rv); chk(16'(rv), 16'h00);
    wr(REG_RATIO, 8'h41);
    rd(REG_STAT, rv); chk(16'(rv), 16'h06);
    tick_gap(n); chk(16'(n), 16'd16);
    key_entry(key, 1'b0); chk(16'(secure), 16'h1);
    rd(REG_CFG, rv); chk(16'(rv), 16'h00);
    @(posedge clk);
    blank_ok <= 1'b1;
    @(posedge clk);
    blank_ok <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(16'(secure), 16'h0);
    for (int s = 0; s < 4; s++) begin
      do_reset({6'h20, 2'(s)});
      chk(16'(secure), (s == 2) ? 16'h0 : 16'h1);
    end
    results();
  end
endmodule : tb
`default_nettype wire
